// ### src/tftc_pkg.sv
// Package holding the register map, field layout and bus codes of the transmit FIFO trigger block.
package tftc_pkg;

   // ----------------------------------------------------------------------
   // Register indices; the byte address is four times the index.
   // ----------------------------------------------------------------------
   localparam logic [5:0] NORMAL_CTL_IDX = 6'h1B;
   localparam logic [5:0] GTS_ONE_CTL_IDX = 6'h1C;

   // ----------------------------------------------------------------------
   // Field positions inside the control registers; only trigger, security and ack request are in both.
   // ----------------------------------------------------------------------
   localparam int TRIGGER_BIT = 0;
   localparam int SECURITY_BIT = 1;
   localparam int ACK_REQ_BIT = 2;
   localparam int INDIRECT_BIT = 3;
   localparam int PENDING_BIT = 4;
   localparam int SLOT_LSB = 3;
   localparam int SLOT_MSB = 5;
   localparam int RETRY_LSB = 6;
   localparam int RETRY_MSB = 7;

   // ----------------------------------------------------------------------
   // Values after reset.
   // ----------------------------------------------------------------------
   localparam logic RESET_FLAG = 1'b0;
   localparam logic [2:0] RESET_SLOT = 3'h0;
   localparam logic [1:0] RESET_RETRY = 2'h0;

   // ----------------------------------------------------------------------
   // Bus answer codes.
   // ----------------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tftc_pkg

// ### src/tftc_tx_launch.sv
// Launch sequencer that hands one FIFO frame and its options to the transmitter.
`timescale 1ns/1ps
`default_nettype none
module tftc_tx_launch
   import tftc_pkg::*;
#(
   parameter int OPT_W = 3
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic trigger,
   input wire logic [OPT_W-1:0] optsIn,
   input wire logic txDone,
   output logic txStart,
   output logic busy,
   output logic [OPT_W-1:0] optsOut
);

   logic txStart_reg;
   logic busy_reg;
   logic [OPT_W-1:0] opts_reg;
   wire logic accept = trigger & ~busy_reg;

   // A trigger while a frame is still out is ignored; the trigger read-back stays at one.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         txStart_reg <= 1'b0;
         busy_reg <= 1'b0;
         opts_reg <= '0;
      end else begin
         txStart_reg <= accept;
         if (accept) begin
            busy_reg <= 1'b1;
            opts_reg <= optsIn;
         end else if (busy_reg && txDone && !txStart_reg) begin
            busy_reg <= 1'b0;
         end
      end
   end

   assign txStart = txStart_reg;
   assign busy = busy_reg;
   assign optsOut = opts_reg;

   // ----------------------------------------------------------------------
   // Checks on the launch sequence.
   // ----------------------------------------------------------------------
   a_start_one_pulse: assert property (@(posedge core_clk) disable iff (!arst_n)
      txStart |=> !txStart && busy) else $error("start pulse not single or busy dropped");
   a_busy_until_done: assert property (@(posedge core_clk) disable iff (!arst_n)
      busy && !txDone |=> busy) else $error("busy dropped without done");
   a_opts_held: assert property (@(posedge core_clk) disable iff (!arst_n)
      busy && !accept |=> $stable(optsOut)) else $error("options changed while busy");

endmodule : tftc_tx_launch
`default_nettype wire

// ### src/tftc_regs.sv
// AXI4-Lite register bank that triggers the normal and GTS one transmit FIFOs.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module tftc_regs
   import tftc_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic core_clk,
   input wire logic arst_n,
   // AXI4-Lite slave.
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Normal FIFO side of the transmitter.
   output logic normalTxStart,
   output logic normalTxIndirect,
   output logic normalTxAckRequest,
   output logic normalTxSecurityEnable,
   output logic normalTxBusy,
   input wire logic normalTxDone,
   input wire logic normalAckValid,
   input wire logic normalAckFramePending,
   // GTS one FIFO side of the transmitter.
   output logic gtsOneTxStart,
   output logic [2:0] gtsOneTxSlot,
   output logic [1:0] gtsOneTxRetryLimit,
   output logic gtsOneTxAckRequest,
   output logic gtsOneTxSecurityEnable,
   output logic gtsOneTxBusy,
   input wire logic gtsOneTxDone,
   input wire logic gtsOneTxSuccess,
   input wire logic [1:0] gtsOneRetriesUsed
);

   // ----------------------------------------------------------------------
   // Address decode.
   // ----------------------------------------------------------------------

   // Word index of a byte address; shared by the read and write paths.
   function automatic logic [5:0] wordIndex(input logic [ADDR_W-1:0] addr);
      wordIndex = 6'(addr[ADDR_W-1:2]);
   endfunction : wordIndex

   logic awready_reg;
   logic wready_reg;
   logic awHave_reg;
   logic wHave_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [7:0] wdata_reg;
   logic wlane_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;

   logic pendingStatusBit_reg;
   logic indirect_reg;
   logic normalAckRequest_reg;
   logic normalSecurityEnable_reg;
   logic [1:0] gtsOneRetryDone_reg;
   logic [2:0] gtsOneSlotNumber_reg;
   logic gtsOneAckRequest_reg;
   logic gtsOneSecurityEnable_reg;

   logic nrmBusy;
   logic g1Busy;
   logic [2:0] nrmOpts;
   logic [6:0] g1Opts;

   // A write fires once address and data are both held and the last answer has gone.
   wire logic wrFire = awHave_reg & wHave_reg & ~bvalid_reg;
   wire logic wrHitNormal = wordIndex(awaddr_reg) == NORMAL_CTL_IDX;
   wire logic wrHitGtsOne = wordIndex(awaddr_reg) == GTS_ONE_CTL_IDX;
   wire logic wrMapped = wrHitNormal | wrHitGtsOne;
   wire logic wrNormal = wrFire & wrHitNormal & wlane_reg;
   wire logic wrGtsOne = wrFire & wrHitGtsOne & wlane_reg;
   wire logic nrmTrigGo = wrNormal & wdata_reg[TRIGGER_BIT] & ~nrmBusy;
   wire logic g1TrigGo = wrGtsOne & wdata_reg[TRIGGER_BIT] & ~g1Busy;
   wire logic rdHitNormal = wordIndex(s_axi_araddr) == NORMAL_CTL_IDX;
   wire logic rdHitGtsOne = wordIndex(s_axi_araddr) == GTS_ONE_CTL_IDX;
   wire logic arFire = s_axi_arvalid & arready_reg;

   // Options handed to the launchers are the values written together with the trigger.
   wire logic [2:0] nrmOptsIn = {wdata_reg[INDIRECT_BIT], wdata_reg[ACK_REQ_BIT], wdata_reg[SECURITY_BIT]};
   wire logic [6:0] g1OptsIn = {wdata_reg[RETRY_MSB:RETRY_LSB], wdata_reg[SLOT_MSB:SLOT_LSB],
                                wdata_reg[ACK_REQ_BIT], wdata_reg[SECURITY_BIT]};

   // Trigger bits read back as one until hardware clears them at frame completion.
   wire logic [7:0] normalReadValue = {3'h0, pendingStatusBit_reg, indirect_reg, normalAckRequest_reg,
                                       normalSecurityEnable_reg, nrmBusy};
   wire logic [7:0] gtsOneReadValue = {gtsOneRetryDone_reg, gtsOneSlotNumber_reg, gtsOneAckRequest_reg,
                                       gtsOneSecurityEnable_reg, g1Busy};
   wire logic [7:0] readValue = rdHitNormal ? normalReadValue : (rdHitGtsOne ? gtsOneReadValue : 8'h00);

   // Pending status moves only on an ack for a frame that asked for one.
   wire logic pendingUpdate = normalAckValid & nrmBusy & normalTxAckRequest;

   // ----------------------------------------------------------------------
   // Write address and data channels, taken in either order.
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         awready_reg <= 1'b1;
         awHave_reg <= 1'b0;
         awaddr_reg <= '0;
      end else if (s_axi_awvalid && awready_reg) begin
         awready_reg <= 1'b0;
         awHave_reg <= 1'b1;
         awaddr_reg <= s_axi_awaddr;
      end else if (wrFire) begin
         awready_reg <= 1'b1;
         awHave_reg <= 1'b0;
      end
   end

   // Only byte lane zero carries register bits; other lanes are dropped.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wready_reg <= 1'b1;
         wHave_reg <= 1'b0;
         wdata_reg <= '0;
         wlane_reg <= 1'b0;
      end else if (s_axi_wvalid && wready_reg) begin
         wready_reg <= 1'b0;
         wHave_reg <= 1'b1;
         wdata_reg <= s_axi_wdata[7:0];
         wlane_reg <= s_axi_wstrb[0];
      end else if (wrFire) begin
         wready_reg <= 1'b1;
         wHave_reg <= 1'b0;
      end
   end

   // Write answer; an unmapped word gets SLVERR and changes nothing.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (wrFire) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Read channel: answer one cycle after the address is taken.
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= '0;
      end else if (arFire) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= (rdHitNormal | rdHitGtsOne) ? RESP_OKAY : RESP_SLVERR;
         rdata_reg <= {24'h000000, readValue};
      end else if (rvalid_reg && s_axi_rready) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Normal FIFO control register.
   // ----------------------------------------------------------------------

   // Reserved upper bits are not stored, so stray ones from software are harmless.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         indirect_reg <= RESET_FLAG;
         normalAckRequest_reg <= RESET_FLAG;
         normalSecurityEnable_reg <= RESET_FLAG;
      end else if (nrmTrigGo) begin
         indirect_reg <= 1'b0;
         normalAckRequest_reg <= 1'b0;
         normalSecurityEnable_reg <= 1'b0;
      end else if (wrNormal) begin
         indirect_reg <= wdata_reg[INDIRECT_BIT];
         normalAckRequest_reg <= wdata_reg[ACK_REQ_BIT];
         normalSecurityEnable_reg <= wdata_reg[SECURITY_BIT];
      end
   end

   // The pending bit is read-only and follows each qualifying ack.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pendingStatusBit_reg <= RESET_FLAG;
      end else if (pendingUpdate) begin
         pendingStatusBit_reg <= normalAckFramePending;
      end
   end

   // ----------------------------------------------------------------------
   // GTS one FIFO control register.
   // ----------------------------------------------------------------------

   // The written retry limit goes straight to the launcher, so the read field is free to show the last success.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         gtsOneSlotNumber_reg <= RESET_SLOT;
         gtsOneAckRequest_reg <= RESET_FLAG;
         gtsOneSecurityEnable_reg <= RESET_FLAG;
      end else if (wrGtsOne) begin
         gtsOneSlotNumber_reg <= wdata_reg[SLOT_MSB:SLOT_LSB];
         gtsOneAckRequest_reg <= wdata_reg[ACK_REQ_BIT];
         gtsOneSecurityEnable_reg <= wdata_reg[SECURITY_BIT];
      end
   end

   // Retries of a failed frame are not reported; the last success stays visible.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         gtsOneRetryDone_reg <= RESET_RETRY;
      end else if (gtsOneTxDone && gtsOneTxSuccess && g1Busy) begin
         gtsOneRetryDone_reg <= gtsOneRetriesUsed;
      end
   end

   // ----------------------------------------------------------------------
   // Launchers.
   // ----------------------------------------------------------------------
   tftc_tx_launch #(
      .OPT_W(3)
   ) u_normal_launch (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .trigger(nrmTrigGo),
      .optsIn(nrmOptsIn),
      .txDone(normalTxDone),
      .txStart(normalTxStart),
      .busy(nrmBusy),
      .optsOut(nrmOpts)
   );

   tftc_tx_launch #(
      .OPT_W(7)
   ) u_gts_one_launch (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .trigger(g1TrigGo),
      .optsIn(g1OptsIn),
      .txDone(gtsOneTxDone),
      .txStart(gtsOneTxStart),
      .busy(g1Busy),
      .optsOut(g1Opts)
   );

   // Output ports; every one comes straight from a flip-flop.
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign normalTxIndirect = nrmOpts[2];
   assign normalTxAckRequest = nrmOpts[1];
   assign normalTxSecurityEnable = nrmOpts[0];
   assign normalTxBusy = nrmBusy;
   assign gtsOneTxRetryLimit = g1Opts[6:5];
   assign gtsOneTxSlot = g1Opts[4:2];
   assign gtsOneTxAckRequest = g1Opts[1];
   assign gtsOneTxSecurityEnable = g1Opts[0];
   assign gtsOneTxBusy = g1Busy;

   // ----------------------------------------------------------------------
   // Assertions and covers.
   // ----------------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   a_pending_follow: assert property (pendingUpdate |=> pendingStatusBit_reg == $past(normalAckFramePending))
      else $error("pending bit did not follow the ack");
   a_pending_hold: assert property (!pendingUpdate |=> $stable(pendingStatusBit_reg))
      else $error("pending bit moved without a qualifying ack");
   a_indirect_launch: assert property (nrmTrigGo |=> normalTxStart && normalTxIndirect == $past(wdata_reg[3]))
      else $error("indirect option not handed to launch");
   a_nrm_ack_launch: assert property (nrmTrigGo |=> normalTxAckRequest == $past(wdata_reg[2]) && normalTxBusy)
      else $error("normal ack request not handed to launch");
   a_nrm_sec_launch: assert property (nrmTrigGo |=> normalTxSecurityEnable == $past(wdata_reg[1]))
      else $error("normal security option not handed to launch");
   a_nrm_opts_clear: assert property (nrmTrigGo |=> !indirect_reg && !normalAckRequest_reg
      && !normalSecurityEnable_reg) else $error("normal options not cleared on trigger");
   a_g1_retry_limit: assert property (g1TrigGo |=> gtsOneTxStart ##0 gtsOneTxRetryLimit == $past(wdata_reg[7:6]))
      else $error("retry limit not handed to launch");
   a_g1_retry_read: assert property (gtsOneTxDone && gtsOneTxSuccess && g1Busy
      |=> gtsOneRetryDone_reg == $past(gtsOneRetriesUsed)) else $error("retry count not captured");
   a_g1_slot: assert property (g1TrigGo |=> gtsOneTxSlot == $past(wdata_reg[5:3]) && gtsOneTxBusy)
      else $error("slot number not handed to launch");
   a_g1_ack: assert property (g1TrigGo |=> gtsOneTxAckRequest == $past(wdata_reg[2]))
      else $error("GTS one ack request not handed to launch");
   a_g1_trig_clear: assert property (g1Busy && gtsOneTxDone && !gtsOneTxStart |=> !gtsOneTxBusy)
      else $error("GTS one trigger not cleared after done");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped before bready");

   c_nrm_launch: cover property (nrmTrigGo ##1 normalTxStart ##[1:20] normalTxDone);
   c_pending_set: cover property (pendingUpdate && normalAckFramePending);
   c_g1_success: cover property (g1TrigGo ##[2:30] (gtsOneTxDone && gtsOneTxSuccess));
   c_unmapped: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);

endmodule : tftc_regs
`default_nettype wire

// ### verification/tb_tx_fifo_trigger_control.sv
// Self-checking testbench for the transmit FIFO trigger register bank.
`timescale 1ns/1ps
`default_nettype none
// Compares two values, counts the comparison and reports a mismatch at once.
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
   $display("[FAIL] t=%0t got %h expected %h", $time, got, exp); end end
module tb_tx_fifo_trigger_control
   import tftc_pkg::*;
;
   // ----------------------------------------------------------------------
   // Design ports, notes queues and counters.
   // ----------------------------------------------------------------------
   logic core_clk = 1'b0, arst_n = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic normalTxStart, normalTxIndirect, normalTxAckRequest, normalTxSecurityEnable, normalTxBusy;
   logic normalTxDone = 1'b0, normalAckValid = 1'b0, normalAckFramePending = 1'b0;
   logic gtsOneTxStart, gtsOneTxAckRequest, gtsOneTxSecurityEnable, gtsOneTxBusy;
   logic [2:0] gtsOneTxSlot;
   logic [1:0] gtsOneTxRetryLimit;
   logic gtsOneTxDone = 1'b0, gtsOneTxSuccess = 1'b0;
   logic [1:0] gtsOneRetriesUsed = 2'h0;
   logic [1:0] expB[$];
   logic [33:0] expR[$];
   logic [2:0] expL[$];
   logic [6:0] expG[$];
   int errors = 0, cmp_count = 0, cycles = 0;
   localparam logic [7:0] NORMAL_ADDR = {NORMAL_CTL_IDX, 2'b00};
   localparam logic [7:0] GTS_ADDR = {GTS_ONE_CTL_IDX, 2'b00};

   tftc_regs #(.ADDR_W(8)) DUT (.core_clk(core_clk), .arst_n(arst_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .normalTxStart(normalTxStart), .normalTxIndirect(normalTxIndirect), .normalTxAckRequest(normalTxAckRequest),
      .normalTxSecurityEnable(normalTxSecurityEnable), .normalTxBusy(normalTxBusy), .normalTxDone(normalTxDone),
      .normalAckValid(normalAckValid), .normalAckFramePending(normalAckFramePending),
      .gtsOneTxStart(gtsOneTxStart), .gtsOneTxSlot(gtsOneTxSlot), .gtsOneTxRetryLimit(gtsOneTxRetryLimit),
      .gtsOneTxAckRequest(gtsOneTxAckRequest), .gtsOneTxSecurityEnable(gtsOneTxSecurityEnable),
      .gtsOneTxBusy(gtsOneTxBusy), .gtsOneTxDone(gtsOneTxDone), .gtsOneTxSuccess(gtsOneTxSuccess),
      .gtsOneRetriesUsed(gtsOneRetriesUsed));

   // ----------------------------------------------------------------------
   // Clock, timeout and closing report.
   // ----------------------------------------------------------------------
   // The clock toggles every 20 ns, half of its 40 ns period.
   always #20 core_clk = ~core_clk;

   // The whole run needs well under a thousand cycles, so a hang is cut short here.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         $display("[FAIL] t=%0t timeout", $time);
         end_sim();
      end
   end

   task automatic end_sim();
      $display("compares %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   // ----------------------------------------------------------------------
   // Watcher: takes the oldest note whenever a result shows at the outputs.
   // ----------------------------------------------------------------------
   // An empty queue means the design produced a result nobody asked for.
   always @(posedge core_clk) begin
      logic [33:0] e;
      if (s_axi_bvalid && s_axi_bready) begin
         e = (expB.size() > 0) ? {32'h0, expB.pop_front()} : 34'h3_FFFF_FFFF;
         `CHK({32'h0, s_axi_bresp}, e)
      end
      if (s_axi_rvalid && s_axi_rready) begin
         e = (expR.size() > 0) ? expR.pop_front() : 34'h3_FFFF_FFFF;
         `CHK({s_axi_rresp, s_axi_rdata}, e)
      end
      if (normalTxStart) begin
         e = (expL.size() > 0) ? {31'h0, expL.pop_front()} : 34'h3_FFFF_FFFF;
         `CHK({31'h0, normalTxIndirect, normalTxAckRequest, normalTxSecurityEnable}, e)
         `CHK(normalTxBusy, 1'b1)
      end
      if (gtsOneTxStart) begin
         e = (expG.size() > 0) ? {27'h0, expG.pop_front()} : 34'h3_FFFF_FFFF;
         `CHK({27'h0, gtsOneTxSlot, gtsOneTxRetryLimit, gtsOneTxAckRequest, gtsOneTxSecurityEnable}, e)
         `CHK(gtsOneTxBusy, 1'b1)
      end
   end

   // ----------------------------------------------------------------------
   // Bus and transmitter driver tasks; each starts and ends just after an edge.
   // ----------------------------------------------------------------------
   task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
      expB.push_back(resp);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'b0;
      @(posedge core_clk);
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
      expR.push_back({resp, 24'h0, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!(s_axi_rvalid && s_axi_rready));
      s_axi_rready <= 1'b0;
      @(posedge core_clk);
   endtask : axi_read

   // Pulses one transmitter input for a single cycle, then lets one idle cycle pass.
   task automatic pulse(input int which, input logic fp);
      if (which == 0) normalTxDone <= 1'b1;
      else if (which == 1) {normalAckValid, normalAckFramePending} <= {1'b1, fp};
      else gtsOneTxDone <= 1'b1;
      @(posedge core_clk);
      {normalTxDone, normalAckValid, gtsOneTxDone} <= 3'b000;
      @(posedge core_clk);
   endtask : pulse

   // ----------------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------------
   initial begin
      logic pend;
      logic [1:0] last;
      logic [7:0] s;
      pend = 1'b0;
      last = 2'h0;
      void'($urandom(14510));
      repeat (3) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      // Reset values and an unmapped word.
      axi_read(NORMAL_ADDR, 8'h00, RESP_OKAY);
      axi_read(GTS_ADDR, 8'h00, RESP_OKAY);
      axi_read(8'h74, 8'h00, RESP_SLVERR);
      axi_write(8'h74, 8'hFF, RESP_SLVERR);
      $display("test reset_and_map done");
      // Every option combination on the normal FIFO; upper bits written as zero.
      for (int o = 0; o < 8; o++) begin
         s = 8'($urandom());
         expL.push_back(3'(o));
         axi_write(NORMAL_ADDR, {4'h0, 3'(o), 1'b1}, RESP_OKAY);
         axi_read(NORMAL_ADDR, {3'h0, pend, 4'h1}, RESP_OKAY);
         pulse(1, s[0]);
         if (o[1]) pend = s[0];
         pulse(0, 1'b0);
         `CHK(normalTxBusy, 1'b0)
         pulse(1, ~pend);
         axi_read(NORMAL_ADDR, {3'h0, pend, 4'h0}, RESP_OKAY);
      end
      $display("test normal_options done");
      // A trigger while busy launches nothing but still writes the options.
      expL.push_back(3'b001);
      axi_write(NORMAL_ADDR, 8'h03, RESP_OKAY);
      axi_write(NORMAL_ADDR, 8'h0F, RESP_OKAY);
      axi_read(NORMAL_ADDR, {3'h0, pend, 4'hF}, RESP_OKAY);
      pulse(0, 1'b0);
      axi_read(NORMAL_ADDR, {3'h0, pend, 4'hE}, RESP_OKAY);
      $display("test normal_busy done");
      // Every retry limit on the GTS one FIFO with random slot, options and outcome.
      for (int r = 0; r < 4; r++) begin
         s = 8'($urandom());
         expG.push_back({s[2:0], 2'(r), s[3], s[4]});
         axi_write(GTS_ADDR, {2'(r), s[2:0], s[3], s[4], 1'b1}, RESP_OKAY);
         axi_read(GTS_ADDR, {last, s[2:0], s[3], s[4], 1'b1}, RESP_OKAY);
         {gtsOneTxSuccess, gtsOneRetriesUsed} <= {s[5], s[7:6]};
         pulse(2, 1'b0);
         `CHK(gtsOneTxBusy, 1'b0)
         if (s[5]) last = s[7:6];
         axi_read(GTS_ADDR, {last, s[2:0], s[3], s[4], 1'b0}, RESP_OKAY);
      end
      $display("test gts_one done");
      `CHK(expB.size() + expR.size() + expL.size() + expG.size(), 0)
      end_sim();
   end

endmodule : tb_tx_fifo_trigger_control
`undef CHK
`default_nettype wire
